// ---- rtl/pte_map.vh ----
// Register map, field positions and reset values of the pulse timer
`ifndef PTE_MAP_VH
`define PTE_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PTE_CTRL_OFS      8'h00
`define PTE_PRESCALE_OFS  8'h04
`define PTE_PERIOD_OFS    8'h08
`define PTE_DUTY_OFS      8'h0C
`define PTE_COUNT_OFS     8'h10
`define PTE_CAPTURE_OFS   8'h14
`define PTE_STATUS_OFS    8'h18
`define PTE_MASK_OFS      8'h1C

// ****************************************
// Control register fields
// ****************************************
`define PTE_CTRL_MODE_LO  0
`define PTE_CTRL_MODE_HI  1
`define PTE_CTRL_INV      2
`define PTE_CTRL_CAP_EN   3
`define PTE_CTRL_SW_TRIG  4

// ****************************************
// Operating modes
// ****************************************
`define PTE_MODE_STOP     2'h0
`define PTE_MODE_PPG      2'h1
`define PTE_MODE_ONESHOT  2'h2
`define PTE_MODE_EVENT    2'h3

// ****************************************
// Prescaler register fields
// ****************************************
`define PTE_PRE_DIV_LO    0
`define PTE_PRE_DIV_HI    1
`define PTE_PRE_EDGE_LO   4
`define PTE_PRE_EDGE_HI   5

// ****************************************
// Edge select codes
// ****************************************
`define PTE_EDGE_FALL     2'h0
`define PTE_EDGE_RISE     2'h1
`define PTE_EDGE_NONE     2'h2
`define PTE_EDGE_BOTH     2'h3

// ****************************************
// Status and mask bits
// ****************************************
`define PTE_ST_PERIOD     0
`define PTE_ST_DUTY       1
`define PTE_ST_CAPTURE    2
`define PTE_ST_ONESHOT    3

// ****************************************
// Reset values
// ****************************************
`define PTE_CTRL_RST      4'h0
`define PTE_PRESCALE_RST  2'h0
`define PTE_EDGE_RST      2'h1
`define PTE_PERIOD_RST    16'hFFFF
`define PTE_DUTY_RST      16'h0000
`define PTE_MASK_RST      4'hF

`endif

// ---- rtl/pte_edge_det.v ----
// Valid edge detector for one timer input pin
`timescale 1ns/1ns
`include "pte_map.vh"

module pte_edge_det (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Pin and selection
    input  wire       pin_i,
    input  wire [1:0] edge_sel_i,
    // Result
    output wire       edge_o
);

    reg prev_reg;

    // Reset to low so a pin held high at reset gives one rising edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin_i;
        end
    end

    assign edge_o = (edge_sel_i == `PTE_EDGE_RISE) ? (pin_i & ~prev_reg) :
                    (edge_sel_i == `PTE_EDGE_FALL) ? (~pin_i & prev_reg) :
                    (edge_sel_i == `PTE_EDGE_BOTH) ? (pin_i ^ prev_reg) : 1'b0;

endmodule // pte_edge_det

// ---- rtl/pte_timer.v ----
// Sixteen-bit pulse timer and event counter with a Wishbone register port
`timescale 1ns/1ns
`include "pte_map.vh"

// Functional notes
// - PPG period is period+1 count clocks, high for duty+1 of them; a one-shot pulse is high for period-duty.
// - Event count is read from the counter register itself.
// - Trigger pin stays live in software one-shot; its edge restarts the pulse.
// - Counter runs as soon as mode is PPG or event; one-shot waits for a trigger; zero stops it.
// - First match after start may slip by up to one count clock.
module pte_timer #(
    parameter CW = 16
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    // Timer pins
    input  wire        trigger_capture_pin_a_i,
    input  wire        capture_pin_b_i,
    output wire        timer_out_o,
    // Interrupt
    output wire        irq_o
);

    // ****************************************
    // Helpers
    // ****************************************
    function [CW-1:0] merge16;
        input [CW-1:0] old;
        input [31:0]   din;
        input [3:0]    sel;
        begin
            merge16 = old;
            if (sel[0]) merge16[7:0] = din[7:0];
            if (sel[1]) merge16[CW-1:8] = din[CW-1:8];
        end
    endfunction

    function reg_hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            reg_hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg  [1:0]    op_mode_reg;
    reg           duty_match_invert_en_reg;
    reg           capture_en_reg;
    reg           oneshot_sw_trigger_reg;
    reg  [1:0]    prescale_div_reg;
    reg  [1:0]    edge_sel_reg;
    reg  [CW-1:0] period_compare_reg;
    reg  [CW-1:0] duty_compare_reg;
    reg  [CW-1:0] timer_count_reg;
    reg  [CW-1:0] capture_reg;
    reg  [3:0]    status_reg;
    reg  [3:0]    mask_reg;
    reg  [2:0]    prescale_cnt_reg;
    reg           run_q_reg;
    reg           oneshot_run_reg;
    reg           out_reg;
    reg           ack_reg;
    reg  [31:0]   dat_reg;
    reg  [31:0]   rd_data;
    reg  [3:0]    status_next;

    wire          access    = cyc_i & stb_i & ~ack_reg;
    wire          wr        = access & we_i;
    wire          rd        = access & ~we_i;
    wire          running   = (op_mode_reg != `PTE_MODE_STOP);
    wire          edge_a;
    wire          edge_b;
    wire          pre_tick;
    wire          trig;
    wire          tick;
    wire          period_hit;
    wire          duty_hit;
    wire          cap_evt;

    // ****************************************
    // Pin edge detection
    // ****************************************
    pte_edge_det u_edge_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (trigger_capture_pin_a_i),
        .edge_sel_i (edge_sel_reg),
        .edge_o     (edge_a)
    );

    pte_edge_det u_edge_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (capture_pin_b_i),
        .edge_sel_i (edge_sel_reg),
        .edge_o     (edge_b)
    );

    // ****************************************
    // Count clock
    // ****************************************
    // Prescaler free-runs and is never cleared on start, so the first tick
    // after start lands anywhere within one count clock
    assign pre_tick = (prescale_div_reg == 2'h0) ? 1'b1 :
                      (prescale_div_reg == 2'h1) ? prescale_cnt_reg[0] :
                      (prescale_div_reg == 2'h2) ? (&prescale_cnt_reg[1:0]) :
                                                   (&prescale_cnt_reg);

    // Event mode counts pin edges instead of prescaled clocks
    assign tick = running & ((op_mode_reg == `PTE_MODE_EVENT) ? edge_a : pre_tick) &
                  ((op_mode_reg != `PTE_MODE_ONESHOT) | oneshot_run_reg);

    // Pin edge stays a valid trigger in software one-shot too
    assign trig = (op_mode_reg == `PTE_MODE_ONESHOT) & (oneshot_sw_trigger_reg | edge_a);

    assign period_hit = tick & ~trig & (timer_count_reg == period_compare_reg);
    assign duty_hit   = tick & ~trig & (timer_count_reg == duty_compare_reg);
    assign cap_evt    = running & capture_en_reg & edge_b;

    // ****************************************
    // Counter and output
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_cnt_reg <= 3'h0;
            run_q_reg        <= 1'b0;
            timer_count_reg  <= {CW{1'b0}};
            oneshot_run_reg  <= 1'b0;
            out_reg          <= 1'b0;
            capture_reg      <= {CW{1'b0}};
        end else begin
            prescale_cnt_reg <= prescale_cnt_reg + 3'h1;
            run_q_reg        <= running;
            if (cap_evt) begin
                capture_reg <= timer_count_reg;
            end
            if (!running) begin
                timer_count_reg <= {CW{1'b0}};
                oneshot_run_reg <= 1'b0;
                out_reg         <= 1'b0;
            end else if (!run_q_reg && op_mode_reg == `PTE_MODE_PPG) begin
                // Counting begins at once; output opens in its high phase
                out_reg <= 1'b1;
                if (tick) begin
                    timer_count_reg <= timer_count_reg + {{(CW-1){1'b0}}, 1'b1};
                end
            end else if (trig) begin
                timer_count_reg <= {CW{1'b0}};
                oneshot_run_reg <= 1'b1;
                out_reg         <= 1'b0;
            end else if (tick) begin
                if (period_hit) begin
                    timer_count_reg <= {CW{1'b0}};
                end else begin
                    timer_count_reg <= timer_count_reg + {{(CW-1){1'b0}}, 1'b1};
                end
                if (duty_hit) begin
                    if (op_mode_reg == `PTE_MODE_PPG && duty_match_invert_en_reg) begin
                        out_reg <= ~out_reg;
                    end else if (op_mode_reg == `PTE_MODE_ONESHOT) begin
                        out_reg <= 1'b1;
                    end
                end
                if (period_hit) begin
                    if (op_mode_reg == `PTE_MODE_PPG) begin
                        out_reg <= 1'b1;
                    end else if (op_mode_reg == `PTE_MODE_ONESHOT) begin
                        out_reg         <= 1'b0;
                        oneshot_run_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            op_mode_reg              <= `PTE_MODE_STOP;
            duty_match_invert_en_reg <= 1'b0;
            capture_en_reg           <= 1'b0;
            oneshot_sw_trigger_reg   <= 1'b0;
            prescale_div_reg         <= `PTE_PRESCALE_RST;
            edge_sel_reg             <= `PTE_EDGE_RST;
            period_compare_reg       <= `PTE_PERIOD_RST;
            duty_compare_reg         <= `PTE_DUTY_RST;
            mask_reg                 <= `PTE_MASK_RST;
        end else begin
            // Trigger bit is a one-cycle strobe and always reads back zero
            oneshot_sw_trigger_reg <= 1'b0;
            if (wr && sel_i[0]) begin
                if (reg_hit(adr_i, `PTE_CTRL_OFS)) begin
                    op_mode_reg              <= dat_i[`PTE_CTRL_MODE_HI:`PTE_CTRL_MODE_LO];
                    duty_match_invert_en_reg <= dat_i[`PTE_CTRL_INV];
                    capture_en_reg           <= dat_i[`PTE_CTRL_CAP_EN];
                    oneshot_sw_trigger_reg   <= dat_i[`PTE_CTRL_SW_TRIG];
                end
                if (reg_hit(adr_i, `PTE_PRESCALE_OFS) && !running) begin
                    // Changing the clock or edge while counting would glitch a tick
                    prescale_div_reg <= dat_i[`PTE_PRE_DIV_HI:`PTE_PRE_DIV_LO];
                    edge_sel_reg     <= dat_i[`PTE_PRE_EDGE_HI:`PTE_PRE_EDGE_LO];
                end
                if (reg_hit(adr_i, `PTE_MASK_OFS)) begin
                    mask_reg <= dat_i[3:0];
                end
            end
            if (wr && reg_hit(adr_i, `PTE_PERIOD_OFS)) begin
                period_compare_reg <= merge16(period_compare_reg, dat_i, sel_i);
            end
            // Duty takes effect on the next compare; a safe rewrite is up to software
            if (wr && reg_hit(adr_i, `PTE_DUTY_OFS)) begin
                duty_compare_reg <= merge16(duty_compare_reg, dat_i, sel_i);
            end
        end
    end

    // ****************************************
    // Read mux and status
    // ****************************************
    always @* begin
        rd_data = 32'h00000000;
        case ({2'h0, adr_i[7:2]})
            `PTE_CTRL_OFS >> 2: rd_data[4:0] = {1'b0, capture_en_reg, duty_match_invert_en_reg, op_mode_reg};
            `PTE_PRESCALE_OFS >> 2: rd_data[5:0] = {edge_sel_reg, 2'h0, prescale_div_reg};
            `PTE_PERIOD_OFS >> 2: rd_data[CW-1:0] = period_compare_reg;
            `PTE_DUTY_OFS >> 2: rd_data[CW-1:0] = duty_compare_reg;
            `PTE_COUNT_OFS >> 2: rd_data[CW-1:0] = timer_count_reg;
            `PTE_CAPTURE_OFS >> 2: rd_data[CW-1:0] = capture_reg;
            `PTE_STATUS_OFS >> 2: rd_data[3:0] = status_reg;
            `PTE_MASK_OFS >> 2: rd_data[3:0] = mask_reg;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Read clears, but an event in the same cycle survives
    always @* begin
        status_next = status_reg;
        if (rd && reg_hit(adr_i, `PTE_STATUS_OFS)) begin
            status_next = 4'h0;
        end
        status_next[`PTE_ST_PERIOD]  = status_next[`PTE_ST_PERIOD] | period_hit;
        status_next[`PTE_ST_DUTY]    = status_next[`PTE_ST_DUTY] | duty_hit;
        status_next[`PTE_ST_CAPTURE] = status_next[`PTE_ST_CAPTURE] | cap_evt;
        status_next[`PTE_ST_ONESHOT] = status_next[`PTE_ST_ONESHOT] |
                                       (period_hit & (op_mode_reg == `PTE_MODE_ONESHOT));
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 4'h0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h00000000;
        end else begin
            status_reg <= status_next;
            ack_reg    <= access;
            if (rd) begin
                dat_reg <= rd_data;
            end
        end
    end

    assign dat_o       = dat_reg;
    assign ack_o       = ack_reg;
    assign timer_out_o = out_reg;
    assign irq_o       = |(status_reg & ~mask_reg);

endmodule // pte_timer

// ---- sim/pte_pin_model.sv ----
// Pin-side partner: drives the trigger/event and capture pins
`timescale 1ns/1ns
module pte_pin_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Commands and watch
    input  wire logic fire_a_i,
    input  wire logic fire_b_i,
    input  wire logic guard_i,
    input  wire logic timer_out_i,
    // Pins
    output wire logic pin_a_o,
    output wire logic pin_b_o
);
    logic [1:0] a_left;
    logic [1:0] b_left;
    logic       busy;
    logic       out_prev;
    logic       a_pend;
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_left <= 2'h0;
            b_left <= 2'h0;
            busy <= 1'b0;
            out_prev <= 1'b0;
            a_pend <= 1'b0;
        end else begin
            out_prev <= timer_out_i;
            // A guarded request is kept and fired once the running pulse ends
            if (a_left == 2'h0 && (fire_a_i || a_pend) && !(guard_i && busy)) begin
                a_left <= 2'h3;
                a_pend <= 1'b0;
                busy <= guard_i;
            end else begin
                if (a_left != 2'h0) a_left <= a_left - 2'h1;
                if (fire_a_i) a_pend <= 1'b1;
                if (out_prev && !timer_out_i) busy <= 1'b0;
            end
            // Both pins are driven as timer inputs
            if (b_left != 2'h0) b_left <= b_left - 2'h1;
            else if (fire_b_i) b_left <= 2'h3;
        end
    end
    assign pin_a_o = (a_left != 2'h0);
    assign pin_b_o = (b_left != 2'h0);
endmodule // pte_pin_model

// ---- sim/pte_timer_monitor.sv ----
// Port-level assertions for the pulse timer
`timescale 1ns/1ns
module pte_timer_monitor (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        trigger_capture_pin_a_i,
    input wire        capture_pin_b_i,
    input wire        timer_out_o,
    input wire        irq_o
);
    wire take = cyc_i && stb_i && !ack_o;
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i) take |=> ack_o)
        else $error("ack missing after request");
    chk_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i) $rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    chk_reset_quiet: assert property (@(posedge clk_i) rst_i |=> !ack_o && !timer_out_o && !irq_o)
        else $error("outputs active after reset");
    chk_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i) !ack_o |-> $stable(dat_o))
        else $error("read data moved outside ack");
    chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !we_i && adr_i >= 8'h20 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |-> dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_stop_out: assert property (@(posedge clk_i) disable iff (rst_i)
        take && we_i && adr_i == 8'h00 && sel_i[0] && dat_i[1:0] == 2'h0 |-> ##2 !timer_out_o [*3])
        else $error("output active after stop");
endmodule // pte_timer_monitor
bind pte_timer pte_timer_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trigger_capture_pin_a_i(trigger_capture_pin_a_i), .capture_pin_b_i(capture_pin_b_i),
    .timer_out_o(timer_out_o), .irq_o(irq_o));

// ---- sim/testbench.sv ----
// Self-checking bench for the pulse timer
`timescale 1ns/1ns
`include "pte_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    logic clk_i, rst_i, cyc, stb, we, fa, fb, guard;
    logic [7:0]  adr;
    logic [31:0] dat, q;
    logic [3:0]  sel;
    wire  [31:0] dat_o;
    wire  ack_o, pin_a, pin_b, tout, irq;
    int   miscompares, check_count, n;
    pte_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .trigger_capture_pin_a_i(pin_a),
        .capture_pin_b_i(pin_b), .timer_out_o(tout), .irq_o(irq));
    pte_pin_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .fire_a_i(fa), .fire_b_i(fb), .guard_i(guard),
        .timer_out_i(tout), .pin_a_o(pin_a), .pin_b_o(pin_b));
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task wb(input [7:0] a, input w, input [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        k = 0;
        // Ack and read data are taken at the edge where ack is sampled high
        do begin
            @(posedge clk_i);
            k++;
            if (k > 20) begin miscompares++; end_sim(); end
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    // Bounded wait for the output level; n counts the cycles taken
    task wt(input b);
        n = 0;
        while (tout !== b) begin
            @(posedge clk_i);
            #1 n++;
            if (n > 300) begin miscompares++; end_sim(); end
        end
    endtask
    task pulse(input b);
        @(posedge clk_i);
        if (b) fb <= 1; else fa <= 1;
        @(posedge clk_i);
        fa <= 0; fb <= 0;
        repeat (6) @(posedge clk_i);
    endtask
    task t_reset;
        logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20};
        logic [31:0] rv[8] = '{32'h0, 32'h10, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'hF, 32'h0};
        for (int i = 0; i < 8; i++) begin
            wb(ra[i], 0, 0);
            `CHK(q, rv[i])
        end
        $display("test reset values done");
    endtask
    task t_ppg;
        wb(`PTE_PERIOD_OFS, 1, 32'h7);
        wb(`PTE_DUTY_OFS, 1, 32'h2);
        wb(`PTE_CTRL_OFS, 1, 32'hD);
        // First high phase may be short by one count clock
        wt(1); wt(0); wt(1);
        wt(0);
        `CHK(n, 3)
        wt(1);
        `CHK(n, 5)
        // Safe duty rewrite while counting
        wb(`PTE_CTRL_OFS, 1, 32'h9);
        wb(`PTE_DUTY_OFS, 1, 32'h4);
        repeat (2) @(posedge clk_i);
        wb(`PTE_CTRL_OFS, 1, 32'hD);
        wb(`PTE_STATUS_OFS, 0, 0);
        // Skip one odd toggle that may follow the return of inversion
        wt(0); wt(1); wt(0); wt(1);
        wt(0);
        `CHK(n, 5)
        wt(1);
        `CHK(n, 3)
        pulse(1);
        `CHK(irq, 1'b0)
        wb(`PTE_CTRL_OFS, 1, 32'h0);
        wb(`PTE_COUNT_OFS, 0, 0);
        `CHK(q, 32'h0)
        `CHK(tout, 1'b0)
        wb(`PTE_MASK_OFS, 1, 32'hD);
        `CHK(irq, 1'b1)
        wb(`PTE_STATUS_OFS, 0, 0);
        `CHK(q, 32'h7)
        #1 `CHK(irq, 1'b0)
        wb(`PTE_MASK_OFS, 1, 32'hF);
        $display("test pulse output done");
    endtask
    task t_event;
        wb(`PTE_PERIOD_OFS, 1, 32'h5);
        wb(`PTE_PRESCALE_OFS, 1, 32'h10);
        wb(`PTE_CTRL_OFS, 1, 32'h3);
        repeat (3) pulse(0);
        wb(`PTE_COUNT_OFS, 0, 0);
        `CHK(q, 32'h3)
        // Edge select must not move while counting
        wb(`PTE_PRESCALE_OFS, 1, 32'h30);
        wb(`PTE_PRESCALE_OFS, 0, 0);
        `CHK(q, 32'h10)
        repeat (3) pulse(0);
        wb(`PTE_COUNT_OFS, 0, 0);
        `CHK(q, 32'h0)
        wb(`PTE_STATUS_OFS, 0, 0);
        `CHK(q[0], 1'b1)
        wb(`PTE_CTRL_OFS, 1, 32'h0);
        $display("test event count done");
    endtask
    task t_oneshot;
        wb(`PTE_PERIOD_OFS, 1, 32'h6);
        wb(`PTE_DUTY_OFS, 1, 32'h2);
        wb(`PTE_STATUS_OFS, 0, 0);
        wb(`PTE_CTRL_OFS, 1, 32'h12);
        wt(1); wt(0);
        `CHK(n, 4)
        wb(`PTE_STATUS_OFS, 0, 0);
        `CHK(q[3], 1'b1)
        guard <= 1;
        pulse(0);
        wt(1);
        `CHK(tout, 1'b1)
        // Second trigger is held by the pin side until the pulse ends
        pulse(0);
        wb(`PTE_STATUS_OFS, 0, 0);
        wt(0);
        wb(`PTE_STATUS_OFS, 0, 0);
        `CHK(q[3], 1'b1)
        wb(`PTE_CTRL_OFS, 1, 32'h0);
        $display("test one-shot done");
    endtask
    initial begin
        rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sel = 0; fa = 0; fb = 0; guard = 0;
        miscompares = 0; check_count = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_ppg();
        t_event();
        t_oneshot();
        end_sim();
    end
endmodule // testbench
